// >>> core/rff_pkg.sv
// Shared constants of the regulator fault flag and mask block
package rff_pkg;

    // Register data width (device bits 23..8 map onto data bits 15..0)
    localparam int RFF_DW = 16;
    // Register index width on the internal register port
    localparam int RFF_AW = 2;

    // Register indexes on the internal register port
    localparam logic [1:0] RFF_IDX_FAULT_MASK = 2'h0;
    localparam logic [1:0] RFF_IDX_SUPPLY_MASK = 2'h1;
    localparam logic [1:0] RFF_IDX_FAULT_FLAGS = 2'h2;
    localparam logic [1:0] RFF_IDX_SUPPLY_FLAGS = 2'h3;

    // Values after power-on reset
    localparam logic [15:0] RFF_FAULT_MASK_RST = 16'h0000;
    localparam logic [15:0] RFF_SUPPLY_MASK_RST = 16'h0000;
    localparam logic [15:0] RFF_FLAGS_RST = 16'h0000;

    // Implemented bits of the fault registers (device bit 22 is reserved)
    localparam logic [15:0] RFF_FAULT_USED = 16'hBFFF;
    // All bits of the supply registers are implemented
    localparam logic [15:0] RFF_SUPPLY_USED = 16'hFFFF;

    // Field positions in the fault registers
    localparam int RFF_POS_THERMAL = 0;   // Over-temperature, low byte
    localparam int RFF_POS_OVERCURRENT = 8;   // Overcurrent, upper byte
    localparam int RFF_POS_FAULT_RSVD = 14;  // Reserved position
    localparam int RFF_POS_HV_OVERCURRENT = 15;

    // Field positions in the supply registers
    localparam int RFF_POS_WAKE_ONE = 0;
    localparam int RFF_POS_WAKE_TWO = 1;
    localparam int RFF_POS_SUPPLY_UVH = 2;
    localparam int RFF_POS_SUPPLY_UVL = 3;
    localparam int RFF_POS_SUPPLY_UV3 = 4;
    localparam int RFF_POS_PREREG_UVH = 5;
    localparam int RFF_POS_PREREG_UVL = 6;
    localparam int RFF_POS_PREREG_OC = 7;
    localparam int RFF_POS_PREREG_OV = 8;
    localparam int RFF_POS_HV_INPUT_UV = 9;
    localparam int RFF_POS_SELFTEST_MASK = 10;  // Mask position of self-test
    localparam int RFF_POS_STANDBY_TIMER = 10;  // Flag position of standby timer
    localparam int RFF_POS_BOOST_OV = 11;
    localparam int RFF_POS_BOOST_UVH = 12;
    localparam int RFF_POS_BOOST_SUPPLY_UVH = 13;
    localparam int RFF_POS_COMM_ERR_MASK = 14;  // Mask position of comm error
    localparam int RFF_POS_SELFTEST_FLAG = 14;  // Flag position of self-test
    localparam int RFF_POS_DIE_THERMAL = 15;

    // Supply flags that are set by a rising edge rather than a level
    localparam logic [15:0] RFF_SUPPLY_EDGE = 16'h0003;

    // Synchroniser depth for inputs from the analog side and the pins
    localparam int RFF_SYNC_STAGES = 3;

endpackage : rff_pkg

// >>> core/rff_flags_masks.sv
module rff_flags_masks
    import rff_pkg::*;
#(
    parameter int SYNC_STAGES = RFF_SYNC_STAGES
) (
    input wire logic mclk,
    input wire logic resetn,
    // Internal register port from the serial control engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [RFF_AW-1:0] reg_addr,
    input wire logic [RFF_DW-1:0] reg_wdata,
    output logic [RFF_DW-1:0] reg_rdata,
    output logic reg_rvalid,
    // Asynchronous fault levels in fault-register bit order
    input wire logic [RFF_DW-1:0] fault_lvl,
    // Asynchronous supply levels and wake pins in supply-register bit order
    input wire logic [RFF_DW-1:0] supply_lvl,
    // Comm error flag held by the serial engine, same clock
    input wire logic comm_error,
    // Interrupt request to the host, active low
    output logic int_req_n
);

    // Register contents
    logic [RFF_DW-1:0] fault_mask_q;   // Fault interrupt mask
    logic [RFF_DW-1:0] supply_mask_q;  // Supply interrupt mask
    logic [RFF_DW-1:0] fault_flags_q;  // Sticky fault flags
    logic [RFF_DW-1:0] supply_flags_q; // Sticky supply flags

    // Synchroniser stages and filtered levels
    logic [RFF_DW-1:0] fault_s1_q;
    logic [RFF_DW-1:0] fault_s2_q;
    logic [RFF_DW-1:0] fault_s3_q;
    logic [RFF_DW-1:0] fault_lvl_q;    // Accepted fault level
    logic [RFF_DW-1:0] supply_s1_q;
    logic [RFF_DW-1:0] supply_s2_q;
    logic [RFF_DW-1:0] supply_s3_q;
    logic [RFF_DW-1:0] supply_lvl_q;   // Accepted supply level

    // Set requests per flag bit
    logic [RFF_DW-1:0] fault_set;
    logic [RFF_DW-1:0] supply_set;
    logic [RFF_DW-1:0] supply_rise;    // Accepted rising transitions

    // Write decodes
    logic wr_fault_mask;
    logic wr_supply_mask;
    logic wr_fault_flags;
    logic wr_supply_flags;

    // Interrupt sources after masking
    logic [RFF_DW-1:0] supply_gate;    // Mask bit seen by each supply flag
    logic int_pending;

    // Register write decodes
    assign wr_fault_mask = reg_wr && (reg_addr == RFF_IDX_FAULT_MASK);
    assign wr_supply_mask = reg_wr && (reg_addr == RFF_IDX_SUPPLY_MASK);
    assign wr_fault_flags = reg_wr && (reg_addr == RFF_IDX_FAULT_FLAGS);
    assign wr_supply_flags = reg_wr && (reg_addr == RFF_IDX_SUPPLY_FLAGS);

    // Per-bit three-stage synchroniser and agreement filter
    genvar gi;
    generate
        for (gi = 0; gi < RFF_DW; gi++) begin : g_sync
            // Shift the raw levels through three stages
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    fault_s1_q[gi] <= 1'b0;
                    fault_s2_q[gi] <= 1'b0;
                    fault_s3_q[gi] <= 1'b0;
                    supply_s1_q[gi] <= 1'b0;
                    supply_s2_q[gi] <= 1'b0;
                    supply_s3_q[gi] <= 1'b0;
                end else begin
                    fault_s1_q[gi] <= fault_lvl[gi];
                    fault_s2_q[gi] <= fault_s1_q[gi];
                    fault_s3_q[gi] <= fault_s2_q[gi];
                    supply_s1_q[gi] <= supply_lvl[gi];
                    supply_s2_q[gi] <= supply_s1_q[gi];
                    supply_s3_q[gi] <= supply_s2_q[gi];
                end
            end

            // Accept a new level only once stages two and three agree
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    fault_lvl_q[gi] <= 1'b0;
                    supply_lvl_q[gi] <= 1'b0;
                end else begin
                    if (fault_s2_q[gi] == fault_s3_q[gi]) begin
                        fault_lvl_q[gi] <= fault_s3_q[gi];
                    end
                    if (supply_s2_q[gi] == supply_s3_q[gi]) begin
                        supply_lvl_q[gi] <= supply_s3_q[gi];
                    end
                end
            end

            // Rising edge as soon as an agreed high meets a low level
            assign supply_rise[gi] = (supply_s2_q[gi] == supply_s3_q[gi])
                                     && supply_s3_q[gi] && !supply_lvl_q[gi];

            // Faults latch while the agreed level is high
            assign fault_set[gi] = RFF_FAULT_USED[gi]
                                   && (fault_lvl_q[gi] ||
                                       ((fault_s2_q[gi] == fault_s3_q[gi])
                                        && fault_s3_q[gi]));
        end
    endgenerate

    // Wake pins latch on an edge, all other supply events on a level
    assign supply_set = (supply_rise & RFF_SUPPLY_EDGE)
                      | (~RFF_SUPPLY_EDGE & (supply_lvl_q | supply_rise));

    // Fault mask register, reserved bit held at zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fault_mask_q <= RFF_FAULT_MASK_RST;
        end else if (wr_fault_mask) begin
            // Reserved position ignores writes
            fault_mask_q <= reg_wdata & RFF_FAULT_USED;
        end
    end

    // Supply mask register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            supply_mask_q <= RFF_SUPPLY_MASK_RST;
        end else if (wr_supply_mask) begin
            supply_mask_q <= reg_wdata & RFF_SUPPLY_USED;
        end
    end

    // Fault flags: set wins over a write-one clear in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fault_flags_q <= RFF_FLAGS_RST;
        end else begin
            if (wr_fault_flags) begin
                fault_flags_q <= ((fault_flags_q & ~reg_wdata) | fault_set)
                                 & RFF_FAULT_USED;
            end else begin
                fault_flags_q <= (fault_flags_q | fault_set) & RFF_FAULT_USED;
            end
        end
    end

    // Supply flags: set wins over a write-one clear in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            supply_flags_q <= RFF_FLAGS_RST;
        end else begin
            if (wr_supply_flags) begin
                supply_flags_q <= (supply_flags_q & ~reg_wdata) | supply_set;
            end else begin
                supply_flags_q <= supply_flags_q | supply_set;
            end
        end
    end

    // Mask seen by each supply flag; self-test flag takes the mask at position 10, standby timer flag gets none
    always_comb begin
        supply_gate = supply_mask_q;
        // Self-test flag is gated by its mask at position 10
        supply_gate[RFF_POS_SELFTEST_FLAG] = supply_mask_q[RFF_POS_SELFTEST_MASK];
        // Standby timer flag has no mask of its own
        supply_gate[RFF_POS_STANDBY_TIMER] = 1'b0;
    end

    // Any unmasked flag, or an unmasked comm error, requests service
    assign int_pending = |(fault_flags_q & ~fault_mask_q)
                      || |(supply_flags_q & ~supply_gate)
                      || (comm_error && !supply_mask_q[RFF_POS_COMM_ERR_MASK]);

    // Interrupt output straight from a flip-flop
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            int_req_n <= 1'b1;
        end else begin
            int_req_n <= !int_pending;
        end
    end

    // Read data returned one cycle after the read strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    // Reserved bits are already zero in storage
                    RFF_IDX_FAULT_MASK: reg_rdata <= fault_mask_q;
                    RFF_IDX_SUPPLY_MASK: reg_rdata <= supply_mask_q;
                    RFF_IDX_FAULT_FLAGS: reg_rdata <= fault_flags_q;
                    RFF_IDX_SUPPLY_FLAGS: reg_rdata <= supply_flags_q;
                endcase
            end
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Reserved fault positions never hold a one
    a_fault_rsvd_zero: assert property (
        !fault_mask_q[RFF_POS_FAULT_RSVD] && !fault_flags_q[RFF_POS_FAULT_RSVD])
        else $error("reserved fault bit is set");

    // A fault mask write stores exactly the implemented bits
    a_fault_mask_wr: assert property (
        wr_fault_mask |=> fault_mask_q == ($past(reg_wdata) & RFF_FAULT_USED))
        else $error("fault mask write not stored");

    // A supply mask write stores all sixteen bits
    a_supply_mask_wr: assert property (
        wr_supply_mask |=> supply_mask_q == $past(reg_wdata))
        else $error("supply mask write not stored");

    // Write one clears a flag unless a new event arrives together
    a_flag_w1c: assert property (
        wr_fault_flags |=>
        (fault_flags_q & $past(reg_wdata) & ~$past(fault_set)) == 16'h0000)
        else $error("write one did not clear fault flag");

    // Writing zero leaves a flag set
    a_flag_w0_keep: assert property (
        wr_supply_flags |=>
        ($past(supply_flags_q) & ~$past(reg_wdata) & ~supply_flags_q) == 16'h0000)
        else $error("supply flag lost on write of zero");

    // A fault event is latched on the next edge and holds without a write
    a_fault_latch: assert property (
        (|fault_set) |=> ((fault_flags_q & $past(fault_set)) == $past(fault_set))
        ##1 ($past(wr_fault_flags) || ((fault_flags_q & $past(fault_set, 2))
                                == $past(fault_set, 2))))
        else $error("fault event not latched");

    // A wake pin rising edge latches its flag one edge later
    a_wake_latch: assert property (
        supply_rise[RFF_POS_WAKE_ONE] |=> supply_flags_q[RFF_POS_WAKE_ONE])
        else $error("wake transition not latched");

    // Self-test failure latches even while masked
    a_selftest_latch: assert property (
        supply_set[RFF_POS_SELFTEST_FLAG] |=> supply_flags_q[RFF_POS_SELFTEST_FLAG])
        else $error("self-test failure not latched");

    // Interrupt follows the unmasked fault flags one edge later
    a_int_follow: assert property (
        (|(fault_flags_q & ~fault_mask_q)) |=> !int_req_n)
        else $error("interrupt not raised for unmasked flag");

    // Masked self-test flag alone does not raise the interrupt
    a_selftest_masked: assert property (
        (supply_flags_q == 16'h4000 && fault_flags_q == 16'h0000 && !comm_error
         && supply_mask_q[RFF_POS_SELFTEST_MASK]) |=> int_req_n)
        else $error("masked self-test raised interrupt");

    // Read returns the flag register one cycle later
    a_read_flags: assert property (
        (reg_rd && reg_addr == RFF_IDX_FAULT_FLAGS) |=>
        (reg_rvalid && reg_rdata == $past(fault_flags_q)))
        else $error("fault flag read mismatch");

    // No flag and no comm error leaves the interrupt released
    a_int_release: assert property (
        (fault_flags_q == 16'h0000 && supply_flags_q == 16'h0000
         && !comm_error) |=> int_req_n)
        else $error("interrupt raised with no flag set");

    // Standby timer flag has no mask and always requests service
    a_standby_unmasked: assert property (
        supply_flags_q[RFF_POS_STANDBY_TIMER] |=> !int_req_n)
        else $error("standby timer flag did not raise interrupt");

    // Unmasked comm error raises the interrupt
    a_comm_int: assert property (
        (comm_error && !supply_mask_q[RFF_POS_COMM_ERR_MASK]) |=> !int_req_n)
        else $error("comm error did not raise interrupt");

    // Masked die thermal flag alone does not raise the interrupt
    a_die_masked: assert property (
        (supply_flags_q == 16'h8000 && fault_flags_q == 16'h0000 && !comm_error
         && supply_mask_q[RFF_POS_DIE_THERMAL]) |=> int_req_n)
        else $error("masked die thermal raised interrupt");

    // Fault mask changes only on its own write
    a_fault_mask_hold: assert property (
        !wr_fault_mask |=> $stable(fault_mask_q))
        else $error("fault mask changed without write");

    // Supply mask changes only on its own write
    a_supply_mask_hold: assert property (
        !wr_supply_mask |=> $stable(supply_mask_q))
        else $error("supply mask changed without write");

    // A fault flag rises only from an event seen one edge earlier
    a_fault_no_spurious: assert property (
        (fault_flags_q & ~$past(fault_flags_q) & ~$past(fault_set)) == 16'h0000)
        else $error("fault flag set without event");

    // A supply flag rises only from an event seen one edge earlier
    a_supply_no_spurious: assert property (
        (supply_flags_q & ~$past(supply_flags_q) & ~$past(supply_set)) == 16'h0000)
        else $error("supply flag set without event");

    // Second wake pin rising edge latches its flag one edge later
    a_wake_two_latch: assert property (
        supply_rise[RFF_POS_WAKE_TWO] |=> supply_flags_q[RFF_POS_WAKE_TWO])
        else $error("second wake transition not latched");

    // Main scenarios
    c_int_raised: cover property (int_req_n ##1 !int_req_n);
    c_flag_cleared: cover property (wr_fault_flags && |(fault_flags_q & reg_wdata));
    c_wake_edge: cover property (supply_rise[RFF_POS_WAKE_TWO]);
    c_masked_event: cover property (|(fault_set & fault_mask_q));
    c_set_beats_clear: cover property (wr_fault_flags && |(fault_set & reg_wdata));

endmodule : rff_flags_masks

// >>> bench/rff_host_model.sv
// Host side of the register port: one request at a time, each strobe held for one cycle
module rff_host_model
    import rff_pkg::*;
(
    input wire logic mclk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [RFF_AW-1:0] reg_addr,
    output logic [RFF_DW-1:0] reg_wdata,
    input wire logic [RFF_DW-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    int rd_timeouts = 0;  // Reads whose answer never came

    // Idle bus from time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 16'h0000;
    end

    // One-cycle write strobe; data inverted once released so nothing stale shows
    task automatic write_reg(input logic [1:0] addr, input logic [15:0] data);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~data;
    endtask : write_reg

    // One-cycle read strobe, answer taken when the valid pulse is seen
    task automatic read_reg(input logic [1:0] addr, output logic [15:0] data);
        int n;
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge mclk);
            #1;
            n++;
        end
        data = reg_rdata;
        if (reg_rvalid !== 1'b1) begin
            rd_timeouts++;
        end
    endtask : read_reg

    // Start-up clear of both flag registers by writing ones
    task automatic clear_all();
        write_reg(RFF_IDX_FAULT_FLAGS, 16'hFFFF);
        write_reg(RFF_IDX_SUPPLY_FLAGS, 16'hFFFF);
    endtask : clear_all
endmodule : rff_host_model

// >>> bench/regulator_fault_flags_masks_tb.sv
// Self-checking bench of the fault flag and mask block
module regulator_fault_flags_masks_tb
    import rff_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic resetn = 1'b0;  // Power-on reset, active low
    logic reg_wr, reg_rd, reg_rvalid, int_req_n;
    logic [1:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [15:0] fault_lvl = 16'h0000;  // Fault sources
    logic [15:0] supply_lvl = 16'h0000;  // Supply sources and wake pins
    logic comm_error = 1'b0;
    int num_errors = 0;
    int num_checks = 0;
    logic [31:0] lfsr = 32'd78476;  // Fixed seed

    always #5 mclk = ~mclk;

    rff_flags_masks DUT (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .fault_lvl(fault_lvl), .supply_lvl(supply_lvl),
        .comm_error(comm_error), .int_req_n(int_req_n));

    rff_host_model HOST (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // Next pseudo-random word
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    // Expected interrupt level for one source, active low
    function automatic logic exp_int_n(input int r, input int b, input int m);
        if (r == 0 && b == RFF_POS_FAULT_RSVD) begin
            return 1'b1;
        end
        if (r == 1 && b == RFF_POS_STANDBY_TIMER) begin
            return 1'b0;
        end
        return (m != 0);
    endfunction : exp_int_n

    // Verdict and end of run
    task automatic final_report();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Read with the host's bounded wait
    task automatic rd(input logic [1:0] a, output logic [15:0] v);
        HOST.read_reg(a, v);
        if (HOST.rd_timeouts != 0) begin
            num_errors++;
            final_report();
        end
    endtask : rd

    // Drive one source register at the clock edge
    task automatic drive(input int r, input logic [15:0] v);
        @(posedge mclk);
        if (r == 0) begin
            fault_lvl <= v;
        end else begin
            supply_lvl <= v;
        end
    endtask : drive

    // Hang guard
    initial begin
        #500us;
        num_errors++;
        final_report();
    end

    // Main sequence
    initial begin
        logic [1:0] fa;
        logic [15:0] ev, used, w;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        check("int after reset", {15'h0, int_req_n}, 16'h0001);
        for (int a = 0; a < 4; a++) begin
            rd(a[1:0], d);
            check("reset value", d, 16'h0000);
        end
        HOST.clear_all();
        // Random mask contents and partial clears
        repeat (8) begin
            lfsr = lfsr_next(lfsr);
            w = lfsr[15:0];
            HOST.write_reg(RFF_IDX_FAULT_MASK, w);
            rd(RFF_IDX_FAULT_MASK, d);
            check("fault mask", d, w & RFF_FAULT_USED);
            HOST.write_reg(RFF_IDX_SUPPLY_MASK, ~w);
            rd(RFF_IDX_SUPPLY_MASK, d);
            check("supply mask", d, ~w);
            drive(0, 16'hFFFF);
            repeat (2) @(posedge mclk);  // Hold past the three-stage synchroniser and agreement filter
            drive(0, 16'h0000);
            repeat (6) @(posedge mclk);
            HOST.write_reg(RFF_IDX_FAULT_FLAGS, w);
            rd(RFF_IDX_FAULT_FLAGS, d);
            check("partial clear", d, RFF_FAULT_USED & ~w);
            HOST.write_reg(RFF_IDX_FAULT_FLAGS, 16'hFFFF);
        end
        // Every source, unmasked then masked
        for (int r = 0; r < 2; r++) begin
            for (int m = 0; m < 2; m++) begin
                for (int b = 0; b < 16; b++) begin
                    fa = (r == 0) ? RFF_IDX_FAULT_FLAGS : RFF_IDX_SUPPLY_FLAGS;
                    ev = 16'h0001 << b;
                    used = (r == 0 && b == RFF_POS_FAULT_RSVD) ? 16'h0000 : ev;
                    HOST.write_reg((r == 0) ? RFF_IDX_FAULT_MASK : RFF_IDX_SUPPLY_MASK,
                        (m != 0) ? 16'hFFFF : 16'h0000);
                    drive(r, ev);
                    repeat (6) @(posedge mclk);
                    #1;
                    check("int level", {15'h0, int_req_n}, {15'h0, exp_int_n(r, b, m)});
                    rd(fa, d);
                    check("flag set", d, used);
                    HOST.write_reg(fa, 16'hFFFF);
                    rd(fa, d);
                    check("clear while high", d,
                        (r == 1 && RFF_SUPPLY_EDGE[b]) ? 16'h0000 : used);
                    drive(r, 16'h0000);
                    repeat (6) @(posedge mclk);
                    HOST.write_reg(fa, 16'hFFFF);
                    rd(fa, d);
                    check("flag cleared", d, 16'h0000);
                    check("int released", {15'h0, int_req_n}, 16'h0001);
                end
            end
        end
        // Comm error interrupt and its mask
        HOST.write_reg(RFF_IDX_SUPPLY_MASK, 16'h0000);
        @(posedge mclk);
        comm_error <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        check("comm int", {15'h0, int_req_n}, 16'h0000);
        HOST.write_reg(RFF_IDX_SUPPLY_MASK, 16'h0001 << RFF_POS_COMM_ERR_MASK);
        repeat (3) @(posedge mclk);
        #1;
        check("comm masked", {15'h0, int_req_n}, 16'h0001);
        final_report();
    end
endmodule : regulator_fault_flags_masks_tb
